// ### pkg/ibis_pkg.sv
// Shared constants and types of the integer and bit-operation execution block
package ibis_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SRC = 8'h04;
  localparam logic [7:0] REG_DST = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_STATUS_REGISTER = 8'h10;
  localparam logic [7:0] REG_BUSY = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] BUF_BASE = 8'h40;
  localparam logic [7:0] BUF_END = 8'h60;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned OP_W = 4;
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned FIELD_W = 5;
  localparam int unsigned CTRL_OFS_LSB = 4;
  localparam int unsigned CTRL_WID_LSB = 10;
  localparam int unsigned CTRL_START_BIT = 31;
  localparam int unsigned SHIFT_W = 6;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int unsigned STATREG_W = 16;
  localparam logic [15:0] STATREG_RESET = 16'h2700;
  localparam int unsigned STATREG_SUPER_BIT = 13;
  localparam int unsigned CCR_C = 0;
  localparam int unsigned CCR_V = 1;
  localparam int unsigned CCR_Z = 2;
  localparam int unsigned CCR_N = 3;
  localparam int unsigned CCR_X = 4;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_PRIV = 1;
  localparam int unsigned IRQ_ILLEGAL = 2;

  // ----------------------------------------------------------------
  // Block move and timing
  // ----------------------------------------------------------------
  localparam int unsigned BLK_BYTES = 16;
  localparam int unsigned BLK_WORDS = BLK_BYTES / 4;
  localparam int unsigned BUF_WORDS = 2 * BLK_WORDS;
  localparam int unsigned BUF_IDX_W = $clog2(BUF_WORDS);
  localparam int unsigned MOVE_CNT_W = 3;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned BREAKPOINT_INSTR_ACK_TIME_NS = 16;
  localparam int unsigned BREAKPOINT_INSTR_ACK_CYCLES = (BREAKPOINT_INSTR_ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BREAKPOINT_INSTR_CNT_W = 8;
  localparam int unsigned FP_DROP_BITS = 29;

  typedef enum logic [3:0] {
    OP_DECIMAL_ADD_EXTEND = 4'h0,
    OP_ADD_WITH_EXTEND = 4'h1,
    OP_AND_IMM_STATUS_PRIV = 4'h2,
    OP_ARITH_SHIFT_LEFT = 4'h3,
    OP_ARITH_SHIFT_RIGHT = 4'h4,
    OP_SINGLE_BIT_CLEAR = 4'h5,
    OP_SINGLE_BIT_SET = 4'h6,
    OP_FIELD_CLEAR = 4'h7,
    OP_FIELD_SET = 4'h8,
    OP_FIELD_EXTRACT_SIGNED = 4'h9,
    OP_FIELD_FIND_FIRST_ONE = 4'ha,
    OP_FIELD_INSERT = 4'hb,
    OP_BREAKPOINT_INSTR = 4'hc,
    OP_BLOCK_MOVE_INSTR = 4'hd,
    OP_FP_ROUND_SINGLE = 4'he,
    OP_FP_ROUND_DOUBLE = 4'hf
  } ibis_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MOVE = 3'b010,
    ST_BKACK = 3'b100
  } ibis_state_e;
endpackage

// ### verilog/ibis_blk_mem.sv
// Small word memory holding the source and destination blocks of a block move
`timescale 1ns/100ps
module ibis_blk_mem #(
  parameter int unsigned DW = 32,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];

  // No reset on the array: contents are undefined until software fills them
  always_ff @(posedge clk) begin
    if (ce && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ### verilog/ibis_core.sv
// Execution block for a slice of integer, bit-field, trap and block-move instructions
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// - Left operand is source, right is destination
// - Block move transfers sixteen bytes per operation
// - Rounding forced to single or double
// - Decimal add sums source, destination, extend
// - Extended add sums source, destination, extend
// - Status AND only in supervisor, else trap
// - Arithmetic shifts store shifted destination back
// - Bit clear: zero flag inverse, bit zeroed
// - Bit set: zero flag inverse, bit set
// - Field clear/set writes zeros or ones
// - Signed extract copies field to data
// - Find first one writes offset to data
// - Field insert writes data low bits
// - Breakpoint runs acknowledge, then illegal trap
module ibis_core #(
  parameter int unsigned BREAKPOINT_INSTR_CYCLES = ibis_pkg::BREAKPOINT_INSTR_ACK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ibis_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output logic bkptAckCycle
);
  import ibis_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] t;
    t = {v, v} << n;
    return t[63:32];
  endfunction

  function automatic logic [31:0] rotr(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] t;
    t = {v, v} >> n;
    return t[31:0];
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] bcdAdd(input logic [7:0] a, input logic [7:0] b,
                                        input logic x);
    logic [4:0] lo;
    logic [4:0] hi;
    logic cl;
    lo = 5'(a[3:0]) + 5'(b[3:0]) + 5'(x);
    cl = (lo > 5'h09);
    if (cl) begin
      lo = lo + 5'h06;
    end
    hi = 5'(a[7:4]) + 5'(b[7:4]) + 5'(cl);
    if (hi > 5'h09) begin
      hi = hi + 5'h06;
      return {1'b1, hi[3:0], lo[3:0]};
    end
    return {1'b0, hi[3:0], lo[3:0]};
  endfunction

  function automatic logic [5:0] leadZeros(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h20;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 6'(31 - i);
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ibis_state_e state_reg;
  logic [31:0] ctrl_reg, src_reg, dst_reg, data_reg;
  logic [STATREG_W-1:0] sr_reg;
  logic [IRQ_W-1:0] irqStat_reg, irqMask_reg;
  logic start_reg, pend_reg, ack_reg, bkptAck_reg;
  logic [31:0] rdat_reg;
  logic [MOVE_CNT_W-1:0] moveCnt_reg;
  logic [BREAKPOINT_INSTR_CNT_W-1:0] bkptCnt_reg;

  ibis_op_e opSel;
  logic [FIELD_W-1:0] fOfs;
  logic [5:0] fWid;
  logic [31:0] fMask, fRot, fIns;
  logic [5:0] shCnt;
  logic [95:0] shWide;
  logic [32:0] sum33;
  logic [8:0] bcd;
  logic [63:0] fpVal, fpRnd;
  logic [31:0] newDst, newData;
  logic [STATREG_W-1:0] newSr;
  logic privTrap, busy, execStrobe, moveWe;
  logic [BUF_IDX_W-1:0] memRdAddr, memWrAddr;
  logic [31:0] memWrData, memRdData;

  assign opSel = ibis_op_e'(ctrl_reg[CTRL_OP_LSB +: OP_W]);
  assign fOfs = ctrl_reg[CTRL_OFS_LSB +: FIELD_W];
  // A width code of zero selects the whole 32-bit word
  assign fWid = (ctrl_reg[CTRL_WID_LSB +: FIELD_W] == 5'h00) ? 6'h20
              : {1'b0, ctrl_reg[CTRL_WID_LSB +: FIELD_W]};
  assign fMask = rotr(~(32'hffffffff >> fWid), fOfs);
  assign fRot = rotl(dst_reg, fOfs) & ~(32'hffffffff >> fWid);
  assign shCnt = src_reg[SHIFT_W-1:0];
  assign busy = (state_reg != ST_IDLE) | start_reg;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic bufHit, accept, wbWrite;
  assign bufHit = (wb_adr_i >= BUF_BASE) && (wb_adr_i < BUF_END);
  // Buffer accesses wait while a move owns the memory ports
  assign accept = wb_cyc_i & wb_stb_i & ~pend_reg & ~ack_reg & ~(bufHit & (state_reg == ST_MOVE));
  assign wbWrite = ce & pend_reg & wb_we_i;

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (ce) begin
      pend_reg <= accept;
      ack_reg <= pend_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdat_reg <= 32'h00000000;
    end else if (ce && pend_reg) begin
      case (wb_adr_i)
        REG_CTRL: rdat_reg <= ctrl_reg;
        REG_SRC: rdat_reg <= src_reg;
        REG_DST: rdat_reg <= dst_reg;
        REG_DATA: rdat_reg <= data_reg;
        REG_STATUS_REGISTER: rdat_reg <= 32'(sr_reg);
        REG_BUSY: rdat_reg <= 32'(busy);
        REG_IRQ_STAT: rdat_reg <= 32'(irqStat_reg);
        REG_IRQ_MASK: rdat_reg <= 32'(irqMask_reg);
        default: rdat_reg <= bufHit ? memRdData : 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------------------------------
  // Operand and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= 32'h00000000;
      start_reg <= 1'b0;
    end else if (ce) begin
      if (wbWrite && wb_adr_i == REG_CTRL && !busy) begin
        ctrl_reg <= byteMerge(ctrl_reg, wb_dat_i, wb_sel_i) & ~(32'h1 << CTRL_START_BIT);
        start_reg <= wb_sel_i[3] & wb_dat_i[CTRL_START_BIT];
      end else begin
        start_reg <= 1'b0;
      end
    end
  end

  assign execStrobe = ce & start_reg & (state_reg == ST_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      src_reg <= 32'h00000000;
    end else if (wbWrite && wb_adr_i == REG_SRC) begin
      src_reg <= byteMerge(src_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dst_reg <= 32'h00000000;
      data_reg <= 32'h00000000;
    end else if (execStrobe) begin
      dst_reg <= newDst;
      data_reg <= newData;
    end else if (wbWrite && wb_adr_i == REG_DST) begin
      dst_reg <= byteMerge(dst_reg, wb_dat_i, wb_sel_i);
    end else if (wbWrite && wb_adr_i == REG_DATA) begin
      data_reg <= byteMerge(data_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_reg <= STATREG_RESET;
    end else if (execStrobe) begin
      sr_reg <= newSr;
    end else if (wbWrite && wb_adr_i == REG_STATUS_REGISTER) begin
      sr_reg <= STATREG_W'(byteMerge(32'(sr_reg), wb_dat_i, wb_sel_i));
    end
  end

  // ----------------------------------------------------------------
  // Single-cycle execution
  // ----------------------------------------------------------------
  always_comb begin
    newDst = dst_reg;
    newData = data_reg;
    newSr = sr_reg;
    privTrap = 1'b0;
    sum33 = {1'b0, src_reg} + {1'b0, dst_reg} + 33'(sr_reg[CCR_X]);
    bcd = bcdAdd(src_reg[7:0], dst_reg[7:0], sr_reg[CCR_X]);
    shWide = 96'(dst_reg) << shCnt;
    fIns = rotr(data_reg << (6'h20 - fWid), fOfs);
    // Rounding ignores NaN and infinity encodings; the mantissa carry may
    // ripple into the exponent, which is the correct result for finite values
    fpVal = {data_reg, dst_reg};
    fpRnd = fpVal;
    case (opSel)
      OP_DECIMAL_ADD_EXTEND: begin
        newDst = {dst_reg[31:8], bcd[7:0]};
        newSr[CCR_C] = bcd[8];
        newSr[CCR_X] = bcd[8];
        if (bcd[7:0] != 8'h00) begin
          newSr[CCR_Z] = 1'b0;
        end
      end
      OP_ADD_WITH_EXTEND: begin
        newDst = sum33[31:0];
        newSr[CCR_C] = sum33[32];
        newSr[CCR_X] = sum33[32];
        newSr[CCR_N] = sum33[31];
        newSr[CCR_V] = (src_reg[31] == dst_reg[31]) && (sum33[31] != src_reg[31]);
        if (sum33[31:0] != 32'h00000000) begin
          newSr[CCR_Z] = 1'b0;
        end
      end
      OP_AND_IMM_STATUS_PRIV: begin
        if (sr_reg[STATREG_SUPER_BIT]) begin
          newSr = sr_reg & src_reg[STATREG_W-1:0];
        end else begin
          privTrap = 1'b1;
        end
      end
      OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT: begin
        if (opSel == OP_ARITH_SHIFT_RIGHT) begin
          shWide = 96'($signed({dst_reg, 32'h00000000}) >>> shCnt);
          newDst = shWide[63:32];
          newSr[CCR_C] = (shCnt != 6'h00) & shWide[31];
          newSr[CCR_V] = 1'b0;
        end else begin
          newDst = shWide[31:0];
          newSr[CCR_C] = (shCnt != 6'h00) & shWide[32];
          newSr[CCR_V] = ($signed(shWide[31:0]) >>> shCnt) != $signed(dst_reg);
        end
        if (shCnt != 6'h00) begin
          newSr[CCR_X] = newSr[CCR_C];
        end
        newSr[CCR_N] = newDst[31];
        newSr[CCR_Z] = (newDst == 32'h00000000);
      end
      OP_SINGLE_BIT_CLEAR, OP_SINGLE_BIT_SET: begin
        newSr[CCR_Z] = ~dst_reg[src_reg[4:0]];
        newDst[src_reg[4:0]] = (opSel == OP_SINGLE_BIT_SET);
      end
      OP_FIELD_CLEAR, OP_FIELD_SET, OP_FIELD_EXTRACT_SIGNED, OP_FIELD_FIND_FIRST_ONE: begin
        newSr[CCR_N] = fRot[31];
        newSr[CCR_Z] = (fRot == 32'h00000000);
        newSr[CCR_V] = 1'b0;
        newSr[CCR_C] = 1'b0;
        if (opSel == OP_FIELD_CLEAR) begin
          newDst = dst_reg & ~fMask;
        end else if (opSel == OP_FIELD_SET) begin
          newDst = dst_reg | fMask;
        end else if (opSel == OP_FIELD_EXTRACT_SIGNED) begin
          newData = 32'($signed(fRot) >>> (6'h20 - fWid));
        end else begin
          newData = 32'(fOfs) + 32'((leadZeros(fRot) < fWid) ? leadZeros(fRot) : fWid);
        end
      end
      OP_FIELD_INSERT: begin
        newDst = (dst_reg & ~fMask) | (fIns & fMask);
        // Bit that lands in the top position once the field is rotated up
        newSr[CCR_N] = fIns[5'h1f - fOfs];
        newSr[CCR_Z] = ((fIns & fMask) == 32'h00000000);
        newSr[CCR_V] = 1'b0;
        newSr[CCR_C] = 1'b0;
      end
      OP_FP_ROUND_SINGLE, OP_FP_ROUND_DOUBLE: begin
        if (opSel == OP_FP_ROUND_SINGLE) begin
          // Nearest-even on the bits a single mantissa cannot hold
          fpRnd = {fpVal[63:FP_DROP_BITS] + 35'(fpVal[FP_DROP_BITS-1]
                   & (fpVal[FP_DROP_BITS] | (|fpVal[FP_DROP_BITS-2:0]))),
                   {FP_DROP_BITS{1'b0}}};
        end
        newData = fpRnd[63:32];
        newDst = fpRnd[31:0];
      end
      default: begin
        newDst = dst_reg;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer for block move and breakpoint acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      moveCnt_reg <= '0;
      bkptCnt_reg <= '0;
      bkptAck_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          moveCnt_reg <= '0;
          bkptCnt_reg <= '0;
          if (start_reg && opSel == OP_BLOCK_MOVE_INSTR) begin
            state_reg <= ST_MOVE;
          end else if (start_reg && opSel == OP_BREAKPOINT_INSTR) begin
            state_reg <= ST_BKACK;
            bkptAck_reg <= 1'b1;
          end
        end
        ST_MOVE: begin
          moveCnt_reg <= moveCnt_reg + 3'h1;
          if (moveCnt_reg == MOVE_CNT_W'(BLK_WORDS)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_BKACK: begin
          bkptCnt_reg <= bkptCnt_reg + 8'h01;
          if (bkptCnt_reg == BREAKPOINT_INSTR_CNT_W'(BREAKPOINT_INSTR_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
            bkptAck_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          bkptAck_reg <= 1'b0;
        end
      endcase
    end
  end

  assign bkptAckCycle = bkptAck_reg;

  // Reading word k lands one cycle later, so writes trail reads by one
  assign moveWe = (state_reg == ST_MOVE) && (moveCnt_reg != '0);
  assign memRdAddr = (state_reg == ST_MOVE) ? BUF_IDX_W'(moveCnt_reg) : wb_adr_i[2 +: BUF_IDX_W];
  assign memWrAddr = moveWe ? BUF_IDX_W'(BLK_WORDS + 32'(moveCnt_reg) - 1) : wb_adr_i[2 +: BUF_IDX_W];
  assign memWrData = moveWe ? memRdData : wb_dat_i;

  ibis_blk_mem #(
    .DW(32),
    .DEPTH(BUF_WORDS),
    .AW(BUF_IDX_W)
  ) blkMem (
    .clk(clk),
    .ce(ce),
    .wrEn(moveWe | (wbWrite & bufHit)),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(memRdAddr),
    .rdData(memRdData)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irqSet, irqClr;
  always_comb begin
    irqSet = '0;
    irqSet[IRQ_DONE] = (execStrobe && !privTrap && opSel != OP_BLOCK_MOVE_INSTR
                        && opSel != OP_BREAKPOINT_INSTR)
                       || (state_reg == ST_MOVE && moveCnt_reg == MOVE_CNT_W'(BLK_WORDS));
    irqSet[IRQ_PRIV] = execStrobe & privTrap;
    irqSet[IRQ_ILLEGAL] = (state_reg == ST_BKACK)
                          && (bkptCnt_reg == BREAKPOINT_INSTR_CNT_W'(BREAKPOINT_INSTR_CYCLES - 1));
    irqClr = (wbWrite && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_reg <= '0;
      irqMask_reg <= '0;
    end else if (ce) begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      if (wbWrite && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
        irqMask_reg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ADD_WITH_EXTEND_DEST: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_ADD_WITH_EXTEND |=> dst_reg == 32'($past(src_reg)
    + $past(dst_reg) + 32'($past(sr_reg[CCR_X]))) && src_reg == $past(src_reg))
    else $error("extended add result or source wrong");
  AST_BCD_DIGITS: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_DECIMAL_ADD_EXTEND && src_reg[3:0] < 4'ha && src_reg[7:4] < 4'ha
    && dst_reg[3:0] < 4'ha && dst_reg[7:4] < 4'ha
    |=> dst_reg[3:0] < 4'ha && dst_reg[7:4] < 4'ha && dst_reg[31:8] == $past(dst_reg[31:8]))
    else $error("decimal add left a non-decimal digit");
  AST_PRIV_TRAP: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_AND_IMM_STATUS_PRIV && !sr_reg[STATREG_SUPER_BIT]
    |=> irqStat_reg[IRQ_PRIV] && sr_reg == $past(sr_reg))
    else $error("user-state status AND did not trap");
  AST_ASR_ONE: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_ARITH_SHIFT_RIGHT && shCnt == 6'h01
    |=> dst_reg == {$past(dst_reg[31]), $past(dst_reg[31:1])} && sr_reg[CCR_C] == $past(dst_reg[0]))
    else $error("arithmetic right shift by one wrong");
  AST_BIT_CLEAR: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_SINGLE_BIT_CLEAR |=> !dst_reg[$past(src_reg[4:0])]
    && sr_reg[CCR_Z] == !$past(dst_reg[src_reg[4:0]]))
    else $error("bit clear wrong");
  AST_BIT_SET: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_SINGLE_BIT_SET |=> dst_reg[$past(src_reg[4:0])]
    && sr_reg[CCR_Z] == !$past(dst_reg[src_reg[4:0]]))
    else $error("bit set wrong");
  AST_FIELD_SET: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_FIELD_SET |=> (dst_reg & $past(fMask)) == $past(fMask)
    && (dst_reg & ~$past(fMask)) == ($past(dst_reg) & ~$past(fMask)))
    else $error("field set touched wrong bits");
  AST_FFO_RANGE: assert property (@(posedge clk) disable iff (rst)
    execStrobe && opSel == OP_FIELD_FIND_FIRST_ONE && fRot != 32'h00000000
    |=> (data_reg - 32'($past(fOfs))) < 32'($past(fWid)))
    else $error("first-one offset outside the field");
  AST_MOVE_LEN: assert property (@(posedge clk) disable iff (rst)
    $fell(state_reg == ST_MOVE) |-> $past(moveCnt_reg) == MOVE_CNT_W'(BLK_WORDS)
    && irqStat_reg[IRQ_DONE])
    else $error("block move did not copy a whole block");
  AST_BREAKPOINT_INSTR_TRAP: assert property (@(posedge clk) disable iff (rst)
    $fell(bkptAck_reg) |-> irqStat_reg[IRQ_ILLEGAL] && $past(state_reg) == ST_BKACK)
    else $error("breakpoint acknowledge not followed by illegal trap");
endmodule

// ### testbench/ibis_testbench.sv
// Self-checking bench for the integer and bit-operation execution block
`timescale 1ns/100ps
module testbench;
  import ibis_pkg::*;
  localparam int unsigned BKC = 4;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, irq, bkptAckCycle;
  int mismatches = 0, tests_run = 0;
  always #2 clk = ~clk;
  ibis_core #(.BREAKPOINT_INSTR_CYCLES(BKC)) u_ibis_core (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .bkptAckCycle(bkptAckCycle));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits on ack without assuming latency; a move may stretch it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'hdead, 32'h0);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic run_op(input logic [3:0] op, input logic [31:0] s, input logic [31:0] d);
    bus(1'b1, REG_SRC, s);
    bus(1'b1, REG_DST, d);
    bus(1'b1, REG_CTRL, 32'h8000_0000 | {28'h0, op});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(REG_STATUS_REGISTER, {16'h0, STATREG_RESET});
    rd_chk(REG_BUSY, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_add_with_extend;
    bus(1'b1, REG_STATUS_REGISTER, 32'h0000_2710);
    run_op(OP_ADD_WITH_EXTEND, 32'h0000_0005, 32'hffff_fff0);
    rd_chk(REG_DST, 32'hffff_fff6);
    run_op(OP_DECIMAL_ADD_EXTEND, 32'h0000_0045, 32'h0000_0038);
    rd_chk(REG_DST, 32'h0000_0083);
    $display("test add_with_extend done");
  endtask
  task automatic t_bits;
    run_op(OP_SINGLE_BIT_CLEAR, 32'h4, 32'h0000_0010);
    rd_chk(REG_DST, 32'h0);
    bus(1'b0, REG_STATUS_REGISTER, 32'h0);
    chk({31'h0, q[CCR_Z]}, 32'h0);
    run_op(OP_SINGLE_BIT_SET, 32'h4, 32'h0);
    rd_chk(REG_DST, 32'h0000_0010);
    bus(1'b0, REG_STATUS_REGISTER, 32'h0);
    chk({31'h0, q[CCR_Z]}, 32'h1);
    $display("test bits done");
  endtask
  task automatic t_move;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, BUF_BASE + 8'(4 * i), 32'h1100_0000 + i);
    end
    run_op(OP_BLOCK_MOVE_INSTR, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(BUF_BASE + 8'(16 + 4 * i), 32'h1100_0000 + i);
    end
    $display("test move done");
  endtask
  task automatic t_breakpoint_instr;
    int n;
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    bus(1'b1, REG_IRQ_MASK, 32'h6);
    run_op(OP_BREAKPOINT_INSTR, 32'h0, 32'h0);
    n = 0;
    @(posedge clk);
    while (bkptAckCycle === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk(n, BKC);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q & 32'h6, 32'h4);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    $display("test breakpoint done");
  endtask
  task automatic t_priv;
    run_op(OP_AND_IMM_STATUS_PRIV, 32'h0000_dfff, 32'h0);
    bus(1'b0, REG_STATUS_REGISTER, 32'h0);
    chk(q & 32'h2000, 32'h0);
    rd_chk(REG_IRQ_STAT, 32'h1);
    run_op(OP_AND_IMM_STATUS_PRIV, 32'h0000_0000, 32'h0);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h30, 32'h0);
    $display("test privilege done");
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_add_with_extend();
    t_bits();
    t_move();
    t_breakpoint_instr();
    t_priv();
    close_out();
  end
  // Far beyond the few hundred cycles the scenarios need
  initial begin
    #80000;
    mismatches++;
    close_out();
  end
endmodule
